// ---- hw/ies_consts.vh ----
`ifndef IES_CONSTS_VH
`define IES_CONSTS_VH

// register byte offsets
`define IES_ADDR_W 8
`define IES_OFF_OPA 8'h00
`define IES_OFF_OPB 8'h04
`define IES_OFF_OPC 8'h08
`define IES_OFF_IMM 8'h0c
`define IES_OFF_CTRL 8'h10
`define IES_OFF_RESULT 8'h14
`define IES_OFF_AUX 8'h18
`define IES_OFF_STATUS 8'h1c
`define IES_OFF_EXCL 8'h20

// control word fields
`define IES_CTRL_OP 4:0
`define IES_CTRL_COND 11:8
`define IES_CTRL_SETF 12
`define IES_CTRL_IMMSEL 13
`define IES_CTRL_WB 14
`define IES_CTRL_SPEC 16

// status word fields
`define IES_ST_MASK 0
`define IES_ST_TAKEN 1
`define IES_ST_EXCLV 2
`define IES_ST_PASS 3
`define IES_ST_WB 4
`define IES_ST_EXSZ 6:5
`define IES_ST_FLAGS 31:28

// operation codes
`define IES_OP_ADD 5'h00
`define IES_OP_SUB 5'h01
`define IES_OP_AND 5'h02
`define IES_OP_MOV 5'h03
`define IES_OP_MACC 5'h04
`define IES_OP_MSUB 5'h05
`define IES_OP_BSWAP 5'h06
`define IES_OP_HSWAP 5'h07
`define IES_OP_LHSWAP 5'h08
`define IES_OP_BZ 5'h09
`define IES_OP_BNZ 5'h0a
`define IES_OP_MSET 5'h0b
`define IES_OP_MCLR 5'h0c
`define IES_OP_S2G 5'h0d
`define IES_OP_G2S 5'h0e
`define IES_OP_LDIA 5'h0f
`define IES_OP_LDDB 5'h10
`define IES_OP_LDSB 5'h11
`define IES_OP_LDSH 5'h12
`define IES_OP_LXW 5'h13
`define IES_OP_LXB 5'h14
`define IES_OP_LXH 5'h15

// transform unit modes
`define IES_XF_BSWAP 3'h0
`define IES_XF_HSWAP 3'h1
`define IES_XF_LHSWAP 3'h2
`define IES_XF_SXTB 3'h3
`define IES_XF_SXTH 3'h4
`define IES_XF_UXTB 3'h5
`define IES_XF_UXTH 3'h6

// exclusive sizes
`define IES_SZ_BYTE 2'h0
`define IES_SZ_HALF 2'h1
`define IES_SZ_WORD 2'h2

// flag positions inside the 4-bit nzcv field
`define IES_F_N 3
`define IES_F_Z 2
`define IES_F_C 1
`define IES_F_V 0

`endif

// ---- hw/ies_byte_xform.v ----
`include "ies_consts.vh"

module ies_byte_xform
(
   input wire [31:0] data_in,
   input wire [2:0] mode_in,
   output reg [31:0] data_out
);

   always @*
   begin
      case (mode_in)
         `IES_XF_BSWAP:
            data_out = {data_in[7:0], data_in[15:8], data_in[23:16], data_in[31:24]};
         `IES_XF_HSWAP:
            data_out = {data_in[23:16], data_in[31:24], data_in[7:0], data_in[15:8]};
         `IES_XF_LHSWAP:
            data_out = {{16{data_in[7]}}, data_in[7:0], data_in[15:8]};
         `IES_XF_SXTB:
            data_out = {{24{data_in[7]}}, data_in[7:0]};
         `IES_XF_SXTH:
            data_out = {{16{data_in[15]}}, data_in[15:0]};
         `IES_XF_UXTB:
            data_out = {24'h000000, data_in[7:0]};
         `IES_XF_UXTH:
            data_out = {16'h0000, data_in[15:0]};
         default:
            data_out = data_in;
      endcase
   end

endmodule // ies_byte_xform

// ---- hw/ies_exec_unit.v ----
`include "ies_consts.vh"

// Behaviour
// - the second operand is either the operand-b register or the immediate register.
// - a condition code is checked against the current flags and a failing one cancels all effects but clearing the pass, taken and writeback bits.
// - multiply-accumulate writes the low 32 bits of a times b plus c.
// - multiply-subtract writes c minus the low 32 bits of a times b.
// - word byte-reverse writes operand a with its four bytes in reverse order.
// - halfword-pair byte-reverse swaps the bytes inside each 16-bit half of operand a.
// - low-half reverse swaps the two low bytes of operand a and sign-extends that half.
// - compare-and-branch takes the branch on zero or non-zero operand a and keeps the flags.
// - the mask-set and mask-clear operations set or clear the interrupt-disable mask.
// - special moves copy flags or mask to a general result, or a general value into them.
// - load-multiple computes increment-after or decrement-before addresses with optional base writeback.
// - signed byte and halfword loads sign-extend the loaded data to 32 bits.
// - exclusive loads of word, byte and halfword size record the address for a later store.
module ies_exec_unit
(
   input wire clk_in,
   input wire sys_rst_in,
   input wire hsel_in,
   input wire [31:0] haddr_in,
   input wire [1:0] htrans_in,
   input wire hwrite_in,
   input wire [2:0] hsize_in,
   input wire [31:0] hwdata_in,
   input wire hready_in,
   output wire [31:0] hrdata_out,
   output wire hreadyout_out,
   output wire hresp_out,
   output wire [3:0] flags_out,
   output wire irq_mask_out
);

   // operand, result and bus state
   reg [31:0] opa_ff, opb_ff, opc_ff, imm_ff, ctrl_ff;
   reg [31:0] result_ff, aux_ff, excl_a_ff, hrdata_ff;
   reg [3:0] flags_ff;
   reg mask_ff, taken_ff, pass_ff, wb_ff, excl_v_ff;
   reg [1:0] excl_sz_ff;
   reg wr_pend_ff, rd_pend_ff, hready_ff;
   // one address register serves both directions, phases never overlap
   reg [`IES_ADDR_W-1:0] addr_ff;

   reg [31:0] nxt_result, nxt_aux, nxt_excl_a, rd_val;
   reg [3:0] nxt_flags;
   reg nxt_mask, nxt_taken, nxt_pass, nxt_wb, nxt_excl_v;
   reg [1:0] nxt_excl_sz;
   reg [2:0] xf_mode;

   wire addr_ok, ctrl_wr, setf, pass;
   wire [4:0] op;
   wire [3:0] cond;
   wire [31:0] opb_sel, macc_res, msub_res, ld_addr, ld_bytes, xf_out, xf_src;
   wire [32:0] add33, sub33;
   wire [63:0] prod;
   wire [5:0] ld_cnt;

   // condition evaluation against nzcv
   function cond_ok;
      input [3:0] c;
      input [3:0] f;
      begin
         case (c)
            4'h0: cond_ok = f[`IES_F_Z];
            4'h1: cond_ok = ~f[`IES_F_Z];
            4'h2: cond_ok = f[`IES_F_C];
            4'h3: cond_ok = ~f[`IES_F_C];
            4'h4: cond_ok = f[`IES_F_N];
            4'h5: cond_ok = ~f[`IES_F_N];
            4'h6: cond_ok = f[`IES_F_V];
            4'h7: cond_ok = ~f[`IES_F_V];
            4'h8: cond_ok = f[`IES_F_C] & ~f[`IES_F_Z];
            4'h9: cond_ok = ~f[`IES_F_C] | f[`IES_F_Z];
            4'ha: cond_ok = (f[`IES_F_N] == f[`IES_F_V]);
            4'hb: cond_ok = (f[`IES_F_N] != f[`IES_F_V]);
            4'hc: cond_ok = ~f[`IES_F_Z] & (f[`IES_F_N] == f[`IES_F_V]);
            4'hd: cond_ok = f[`IES_F_Z] | (f[`IES_F_N] != f[`IES_F_V]);
            default: cond_ok = 1'b1;
         endcase
      end
   endfunction

   // population count of the register list
   function [5:0] bit_count;
      input [15:0] list;
      integer i;
      begin
         bit_count = 6'h00;
         for (i = 0; i < 16; i = i + 1)
            bit_count = bit_count + {5'h00, list[i]};
      end
   endfunction

   // n and z from a result, c and v passed through
   function [3:0] nz_flags;
      input [31:0] r;
      input cy;
      input v;
      begin
         nz_flags = {r[31], (r == 32'h00000000), cy, v};
      end
   endfunction

   assign addr_ok = hsel_in & htrans_in[1] & hready_in;
   assign ctrl_wr = wr_pend_ff & (addr_ff == `IES_OFF_CTRL);
   assign op = hwdata_in[`IES_CTRL_OP];
   assign cond = hwdata_in[`IES_CTRL_COND];
   assign setf = hwdata_in[`IES_CTRL_SETF];
   assign pass = cond_ok(cond, flags_ff);
   assign opb_sel = hwdata_in[`IES_CTRL_IMMSEL] ? imm_ff : opb_ff;
   assign add33 = {1'b0, opa_ff} + {1'b0, opb_sel};
   assign sub33 = {1'b0, opa_ff} + {1'b0, ~opb_sel} + 33'h000000001;
   assign prod = opa_ff * opb_ff;
   assign macc_res = prod[31:0] + opc_ff;
   assign msub_res = opc_ff - prod[31:0];
   assign ld_addr = opa_ff + opb_sel;
   assign ld_cnt = bit_count(opb_ff[15:0]);
   assign ld_bytes = {24'h000000, ld_cnt, 2'h0};
   // loads transform the fetched data, reverses transform operand a
   assign xf_src = (op >= `IES_OP_LDSB) ? opc_ff : opa_ff;

   always @*
   begin
      case (op)
         `IES_OP_BSWAP: xf_mode = `IES_XF_BSWAP;
         `IES_OP_HSWAP: xf_mode = `IES_XF_HSWAP;
         `IES_OP_LHSWAP: xf_mode = `IES_XF_LHSWAP;
         `IES_OP_LDSB: xf_mode = `IES_XF_SXTB;
         `IES_OP_LDSH: xf_mode = `IES_XF_SXTH;
         `IES_OP_LXB: xf_mode = `IES_XF_UXTB;
         `IES_OP_LXH: xf_mode = `IES_XF_UXTH;
         default: xf_mode = 3'h7;
      endcase
   end

   ies_byte_xform u_xform
   (
      .data_in(xf_src),
      .mode_in(xf_mode),
      .data_out(xf_out)
   );

   // execution, taken when software writes the control word
   always @*
   begin
      nxt_result = result_ff;
      nxt_aux = aux_ff;
      nxt_flags = flags_ff;
      nxt_mask = mask_ff;
      nxt_taken = taken_ff;
      nxt_pass = pass_ff;
      nxt_wb = wb_ff;
      nxt_excl_v = excl_v_ff;
      nxt_excl_a = excl_a_ff;
      nxt_excl_sz = excl_sz_ff;
      if (ctrl_wr)
      begin
         nxt_pass = pass;
         nxt_taken = 1'b0;
         nxt_wb = 1'b0;
         // a failed condition keeps every result and flag as it was
         if (pass)
         begin
            case (op)
               `IES_OP_ADD:
               begin
                  nxt_result = add33[31:0];
                  if (setf)
                     nxt_flags = nz_flags(add33[31:0], add33[32],
                        (opa_ff[31] == opb_sel[31]) & (add33[31] != opa_ff[31]));
               end
               `IES_OP_SUB:
               begin
                  nxt_result = sub33[31:0];
                  if (setf)
                     nxt_flags = nz_flags(sub33[31:0], sub33[32],
                        (opa_ff[31] != opb_sel[31]) & (sub33[31] != opa_ff[31]));
               end
               `IES_OP_AND:
               begin
                  nxt_result = opa_ff & opb_sel;
                  if (setf)
                     nxt_flags = nz_flags(opa_ff & opb_sel, flags_ff[`IES_F_C],
                        flags_ff[`IES_F_V]);
               end
               `IES_OP_MOV:
               begin
                  nxt_result = opb_sel;
                  if (setf)
                     nxt_flags = nz_flags(opb_sel, flags_ff[`IES_F_C], flags_ff[`IES_F_V]);
               end
               // multiply forms never touch the flags
               `IES_OP_MACC: nxt_result = macc_res;
               `IES_OP_MSUB: nxt_result = msub_res;
               `IES_OP_BSWAP, `IES_OP_HSWAP, `IES_OP_LHSWAP:
                  nxt_result = xf_out;
               `IES_OP_BZ, `IES_OP_BNZ:
               begin
                  // branch target from the immediate, flags left alone
                  nxt_result = imm_ff;
                  nxt_taken = (opa_ff == 32'h00000000) ^ (op == `IES_OP_BNZ);
               end
               `IES_OP_MSET: nxt_mask = 1'b1;
               `IES_OP_MCLR: nxt_mask = 1'b0;
               `IES_OP_S2G:
               begin
                  if (hwdata_in[`IES_CTRL_SPEC])
                     nxt_result = {31'h00000000, mask_ff};
                  else
                     nxt_result = {flags_ff, 28'h0000000};
               end
               `IES_OP_G2S:
               begin
                  if (hwdata_in[`IES_CTRL_SPEC])
                     nxt_mask = opa_ff[0];
                  else
                     nxt_flags = opa_ff[31:28];
               end
               `IES_OP_LDIA:
               begin
                  nxt_result = opa_ff;
                  nxt_aux = opa_ff + ld_bytes;
                  nxt_wb = hwdata_in[`IES_CTRL_WB];
               end
               `IES_OP_LDDB:
               begin
                  nxt_result = opa_ff - ld_bytes;
                  nxt_aux = opa_ff - ld_bytes;
                  nxt_wb = hwdata_in[`IES_CTRL_WB];
               end
               `IES_OP_LDSB, `IES_OP_LDSH:
               begin
                  nxt_result = xf_out;
                  nxt_aux = ld_addr;
               end
               `IES_OP_LXW, `IES_OP_LXB, `IES_OP_LXH:
               begin
                  nxt_result = (op == `IES_OP_LXW) ? opc_ff : xf_out;
                  nxt_aux = ld_addr;
                  nxt_excl_v = 1'b1;
                  nxt_excl_a = ld_addr;
                  nxt_excl_sz = (op == `IES_OP_LXW) ? `IES_SZ_WORD :
                     ((op == `IES_OP_LXB) ? `IES_SZ_BYTE : `IES_SZ_HALF);
               end
               default: nxt_result = result_ff;
            endcase
         end
      end
   end

   // read mux, unmapped offsets read as zero
   always @*
   begin
      case (addr_ff)
         `IES_OFF_OPA: rd_val = opa_ff;
         `IES_OFF_OPB: rd_val = opb_ff;
         `IES_OFF_OPC: rd_val = opc_ff;
         `IES_OFF_IMM: rd_val = imm_ff;
         `IES_OFF_CTRL: rd_val = ctrl_ff;
         `IES_OFF_RESULT: rd_val = result_ff;
         `IES_OFF_AUX: rd_val = aux_ff;
         `IES_OFF_STATUS:
         begin
            rd_val = 32'h00000000;
            rd_val[`IES_ST_FLAGS] = flags_ff;
            rd_val[`IES_ST_MASK] = mask_ff;
            rd_val[`IES_ST_TAKEN] = taken_ff;
            rd_val[`IES_ST_EXCLV] = excl_v_ff;
            rd_val[`IES_ST_PASS] = pass_ff;
            rd_val[`IES_ST_WB] = wb_ff;
            rd_val[`IES_ST_EXSZ] = excl_sz_ff;
         end
         `IES_OFF_EXCL: rd_val = excl_a_ff;
         default: rd_val = 32'h00000000;
      endcase
   end

   // bus slave: writes without wait, reads with one wait state so
   // read data always comes from a flop and sees the newest result
   always @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         wr_pend_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         addr_ff <= 8'h00;
         hrdata_ff <= 32'h00000000;
         hready_ff <= 1'b1;
      end
      else
      begin
         wr_pend_ff <= addr_ok & hwrite_in;
         rd_pend_ff <= addr_ok & ~hwrite_in;
         if (addr_ok)
            addr_ff <= haddr_in[`IES_ADDR_W-1:0];
         hready_ff <= ~(addr_ok & ~hwrite_in);
         if (rd_pend_ff)
            hrdata_ff <= rd_val;
      end
   end

   // software registers
   always @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         opa_ff <= 32'h00000000;
         opb_ff <= 32'h00000000;
         opc_ff <= 32'h00000000;
         imm_ff <= 32'h00000000;
         ctrl_ff <= 32'h00000000;
      end
      else if (wr_pend_ff)
      begin
         case (addr_ff)
            `IES_OFF_OPA: opa_ff <= hwdata_in;
            `IES_OFF_OPB: opb_ff <= hwdata_in;
            `IES_OFF_OPC: opc_ff <= hwdata_in;
            `IES_OFF_IMM: imm_ff <= hwdata_in;
            `IES_OFF_CTRL: ctrl_ff <= hwdata_in;
            default: ctrl_ff <= ctrl_ff;
         endcase
      end
   end

   // execution state
   always @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         result_ff <= 32'h00000000;
         aux_ff <= 32'h00000000;
         flags_ff <= 4'h0;
         mask_ff <= 1'b0;
         taken_ff <= 1'b0;
         pass_ff <= 1'b0;
         wb_ff <= 1'b0;
         excl_v_ff <= 1'b0;
         excl_a_ff <= 32'h00000000;
         excl_sz_ff <= 2'h0;
      end
      else
      begin
         result_ff <= nxt_result;
         aux_ff <= nxt_aux;
         flags_ff <= nxt_flags;
         mask_ff <= nxt_mask;
         taken_ff <= nxt_taken;
         pass_ff <= nxt_pass;
         wb_ff <= nxt_wb;
         excl_v_ff <= nxt_excl_v;
         excl_a_ff <= nxt_excl_a;
         excl_sz_ff <= nxt_excl_sz;
      end
   end

   assign hrdata_out = hrdata_ff;
   assign hreadyout_out = hready_ff;
   // always okay
   assign hresp_out = 1'b0;
   assign flags_out = flags_ff;
   assign irq_mask_out = mask_ff;

endmodule // ies_exec_unit

// ---- sim/ies_ahb_host.sv ----
module ies_ahb_host
(
   input wire logic clk_in,
   input wire logic hready_in,
   input wire logic [31:0] hrdata_in,
   output logic hsel_out,
   output logic [31:0] haddr_out,
   output logic [1:0] htrans_out,
   output logic hwrite_out,
   output logic [2:0] hsize_out,
   output logic [31:0] hwdata_out
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      {hsel_out, htrans_out, hwrite_out} = 4'h0;
      {haddr_out, hwdata_out} = 64'h0;
      hsize_out = 3'h2;
   end

   // released address and data lines show the inverse of their last value, never a stale copy
   task automatic xfer(input logic wr, input logic [7:0] ad, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge clk_in);
      hsel_out <= 1'b1;
      haddr_out <= {24'h0, ad};
      htrans_out <= 2'h2;
      hwrite_out <= wr;
      @(posedge clk_in);
      while (hready_in !== 1'b1) @(posedge clk_in);
      hsel_out <= 1'b0;
      htrans_out <= 2'h0;
      haddr_out <= ~haddr_out;
      hwdata_out <= wr ? d : ~hwdata_out;
      @(posedge clk_in);
      while (hready_in !== 1'b1) @(posedge clk_in);
      q = hrdata_in;
      hwdata_out <= ~hwdata_out;
   endtask
endmodule // ies_ahb_host

// ---- sim/ies_exec_unit_sva.sv ----
`include "ies_consts.vh"

module ies_exec_unit_sva
(
   input wire clk_in,
   input wire sys_rst_in,
   input wire hsel_in,
   input wire [31:0] haddr_in,
   input wire [1:0] htrans_in,
   input wire hwrite_in,
   input wire [31:0] hwdata_in,
   input wire hready_in,
   input wire [31:0] hrdata_out,
   input wire hreadyout_out,
   input wire hresp_out,
   input wire [3:0] flags_out,
   input wire irq_mask_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // [0] control write in data phase, [1] read in data phase
   logic [1:0] ph_ff;
   logic [1:0] nxt_ph;
   wire take = hsel_in & htrans_in[1] & hready_in;

   assign nxt_ph = {take & ~hwrite_in, take & hwrite_in & (haddr_in[7:0] == `IES_OFF_CTRL)};

   always_ff @(posedge clk_in or posedge sys_rst_in)
      if (sys_rst_in)
         ph_ff <= 2'h0;
      else
         ph_ff <= nxt_ph;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);

   sequence rd_take;
      take && !hwrite_in;
   endsequence
   sequence one_wait;
      !hreadyout_out ##1 hreadyout_out;
   endsequence

   a_resp_okay:
      assert property (hresp_out == 1'b0) else $error("error response");
   a_read_wait:
      assert property (rd_take |=> one_wait) else $error("read wait state wrong");
   a_write_nowait:
      assert property (take && hwrite_in |=> hreadyout_out) else $error("write stalled");
   a_flags_quiet:
      assert property (!ph_ff[0] |=> $stable(flags_out)) else $error("flags moved");
   a_mask_quiet:
      assert property (!ph_ff[0] |=> $stable(irq_mask_out)) else $error("mask moved");
   a_rdata_hold:
      assert property (!ph_ff[1] |=> $stable(hrdata_out)) else $error("read data moved");
   a_status_mirror:
      assert property (rd_take ##0 haddr_in[7:0] == `IES_OFF_STATUS |-> ##2
         (hrdata_out[0] == irq_mask_out && hrdata_out[31:28] == flags_out))
      else $error("status disagrees with outputs");
   a_mask_set:
      assert property (ph_ff[0] && hwdata_in[11:9] == 3'h7
         && hwdata_in[`IES_CTRL_OP] == `IES_OP_MSET |=> irq_mask_out)
      else $error("mask not set");
   a_mask_clear:
      assert property (ph_ff[0] && hwdata_in[11:9] == 3'h7
         && hwdata_in[`IES_CTRL_OP] == `IES_OP_MCLR |=> !irq_mask_out)
      else $error("mask not cleared");
   a_unmapped_zero:
      assert property (rd_take ##0 haddr_in[7:0] > 8'h20 |-> ##2 hrdata_out == 32'h0)
      else $error("unmapped read not zero");
endmodule // ies_exec_unit_sva

bind ies_exec_unit ies_exec_unit_sva u_sva
(
   .clk_in(clk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
   .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in),
   .hready_in(hready_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
   .hresp_out(hresp_out), .flags_out(flags_out), .irq_mask_out(irq_mask_out)
);

// ---- sim/test_instruction_execute_subset.sv ----
`include "ies_consts.vh"

module test_instruction_execute_subset;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] AL = 32'h0e00;
   localparam logic [31:0] SF = 32'h1000;
   localparam logic [31:0] IS = 32'h2000;
   localparam logic [31:0] WB = 32'h4000;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   wire hsel, hwrite, hrdy, hresp, mask;
   wire [31:0] haddr, hwdata, hrdata;
   wire [1:0] htrans;
   wire [2:0] hsize;
   wire [3:0] flags;
   int n_errors = 0;
   int checked = 0;
   logic [31:0] a, b, c, imm, q, res;
   logic [3:0] fl;
   logic ok;

   always #10 clk_in = ~clk_in;

   ies_ahb_host u_host (.clk_in(clk_in), .hready_in(hrdy), .hrdata_in(hrdata), .hsel_out(hsel),
      .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize),
      .hwdata_out(hwdata));
   ies_exec_unit u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
      .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy),
      .hresp_out(hresp), .flags_out(flags), .irq_mask_out(mask));

   task automatic tally_and_finish();
      if (n_errors == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      u_host.xfer(1'b1, ad, d, q);
   endtask

   task automatic rd(input logic [7:0] ad);
      u_host.xfer(1'b0, ad, 32'h0, q);
   endtask

   task automatic rdc(input logic [7:0] ad, input logic [31:0] e);
      rd(ad);
      chk(q, e);
   endtask

   // the delay lets the executing edge's updates land before outputs are read
   task automatic run(input logic [31:0] ctrl);
      wr(`IES_OFF_CTRL, ctrl);
      #1;
   endtask

   task automatic load(input logic [31:0] x, y, z, i);
      wr(`IES_OFF_OPA, x);
      wr(`IES_OFF_OPB, y);
      wr(`IES_OFF_OPC, z);
      wr(`IES_OFF_IMM, i);
   endtask

   function automatic logic cond_ok(input logic [3:0] cc, input logic [3:0] f);
      logic n, z, cy, v, r;
      {n, z, cy, v} = f;
      case (cc[3:1])
         3'h0: r = z;
         3'h1: r = cy;
         3'h2: r = n;
         3'h3: r = v;
         3'h4: r = cy & ~z;
         3'h5: r = n == v;
         3'h6: r = ~z & (n == v);
         default: r = 1'b1;
      endcase
      return (cc[0] && cc < 4'he) ? ~r : r;
   endfunction

   function automatic logic [3:0] add_fl(input logic [31:0] x, input logic [31:0] y);
      logic [32:0] s;
      s = {1'b0, x} + {1'b0, y};
      return {s[31], s[31:0] == 32'h0, s[32], x[31] == y[31] && s[31] != x[31]};
   endfunction

   // carry is the no-borrow bit of x minus y
   function automatic logic [3:0] sub_fl(input logic [31:0] x, input logic [31:0] y);
      logic [32:0] s;
      s = {1'b0, x} + {1'b0, ~y} + 33'h1;
      return {s[31], s[31:0] == 32'h0, s[32], x[31] != y[31] && s[31] != x[31]};
   endfunction

   function automatic logic [31:0] ld_exp(input int k, input logic [31:0] d);
      case (k)
         0: return {{24{d[7]}}, d[7:0]};
         1: return {{16{d[15]}}, d[15:0]};
         2: return d;
         3: return {24'h0, d[7:0]};
         default: return {16'h0, d[15:0]};
      endcase
   endfunction

   initial
   begin
      #2_000_000;
      n_errors++;
      tally_and_finish();
   end

   initial
   begin
      q = $urandom(32'he0b45f39);
      repeat (4) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         a = (i == 0) ? 32'hffff_ffff : $urandom;
         b = $urandom;
         c = $urandom;
         imm = $urandom;
         load(a, b, c, imm);
         fl = add_fl(a, i[0] ? imm : b);
         run(AL | SF | (i[0] ? IS : 32'h0) | `IES_OP_ADD);
         rdc(`IES_OFF_RESULT, a + (i[0] ? imm : b));
         chk({28'h0, flags}, {28'h0, fl});
         run(AL | `IES_OP_MACC);
         rdc(`IES_OFF_RESULT, a * b + c);
         run(AL | `IES_OP_MSUB);
         rdc(`IES_OFF_RESULT, c - a * b);
         chk({28'h0, flags}, {28'h0, fl});
         run(AL | `IES_OP_BSWAP);
         rdc(`IES_OFF_RESULT, {a[7:0], a[15:8], a[23:16], a[31:24]});
         run(AL | `IES_OP_HSWAP);
         rdc(`IES_OFF_RESULT, {a[23:16], a[31:24], a[7:0], a[15:8]});
         run(AL | `IES_OP_LHSWAP);
         rdc(`IES_OFF_RESULT, {{16{a[7]}}, a[7:0], a[15:8]});
         run(AL | SF | `IES_OP_AND);
         fl[3:2] = {a[31] & b[31], (a & b) == 32'h0};
         chk({28'h0, flags}, {28'h0, fl});
         run(AL | SF | `IES_OP_SUB);
         rdc(`IES_OFF_RESULT, a - b);
         chk({28'h0, flags}, {28'h0, sub_fl(a, b)});
      end
      wr(`IES_OFF_IMM, 32'h0);
      run(AL | IS | `IES_OP_MOV);
      res = 32'h0;
      for (int f = 0; f < 16; f++)
      begin
         fl = f[3:0];
         wr(`IES_OFF_OPA, {fl, 28'h0});
         run(AL | `IES_OP_G2S);
         chk({28'h0, flags}, {28'h0, fl});
         for (int cc = 0; cc < 16; cc++)
         begin
            imm = $urandom;
            ok = cond_ok(cc[3:0], fl);
            wr(`IES_OFF_IMM, imm);
            run({cc[3:0], 8'h0} | IS | `IES_OP_MOV);
            res = ok ? imm : res;
            rdc(`IES_OFF_RESULT, res);
            rd(`IES_OFF_STATUS);
            chk({31'h0, q[3]}, {31'h0, ok});
         end
      end
      chk({28'h0, flags}, {28'h0, fl});
      wr(`IES_OFF_RESULT, ~res);
      rdc(`IES_OFF_RESULT, res);
      rdc(8'h40, 32'h0);
      run(AL | `IES_OP_S2G);
      rd(`IES_OFF_RESULT);
      chk({28'h0, q[31:28]}, {28'h0, fl});
      for (int i = 0; i < 2; i++)
      begin
         wr(`IES_OFF_OPA, i ? 32'h0 : 32'h8000_0000);
         run(AL | `IES_OP_BZ);
         rd(`IES_OFF_STATUS);
         chk({31'h0, q[1]}, {31'h0, i[0]});
         run(AL | `IES_OP_BNZ);
         rd(`IES_OFF_STATUS);
         chk({31'h0, q[1]}, {31'h0, ~i[0]});
         chk({28'h0, flags}, {28'h0, fl});
      end
      run(32'h100 | `IES_OP_MSET);
      chk({31'h0, mask}, 32'h0);
      run(AL | `IES_OP_MSET);
      chk({31'h0, mask}, 32'h1);
      run(AL | `IES_OP_MCLR);
      chk({31'h0, mask}, 32'h0);
      wr(`IES_OFF_OPA, 32'h1);
      run(AL | 32'h1_0000 | `IES_OP_G2S);
      chk({31'h0, mask}, 32'h1);
      chk({28'h0, flags}, {28'h0, fl});
      run(AL | 32'h1_0000 | `IES_OP_S2G);
      rdc(`IES_OFF_RESULT, 32'h1);
      for (int i = 0; i < 4; i++)
      begin
         a = $urandom & 32'hffff_fffc;
         b = (i == 0) ? 32'hffff : $urandom;
         load(a, b, 32'h0, 32'h0);
         c = 4 * $countones(b[15:0]);
         run(AL | (i[1] ? WB : 32'h0) | (i[0] ? `IES_OP_LDDB : `IES_OP_LDIA));
         rdc(`IES_OFF_RESULT, i[0] ? a - c : a);
         if (i[1]) rdc(`IES_OFF_AUX, i[0] ? a - c : a + c);
         rd(`IES_OFF_STATUS);
         chk({31'h0, q[4]}, {31'h0, i[1]});
      end
      for (int i = 0; i < 10; i++)
      begin
         a = $urandom;
         imm = $urandom & 32'hfff;
         c = (i < 5) ? 32'h0000_8080 : $urandom;
         load(a, 32'h0, c, imm);
         run(AL | IS | (`IES_OP_LDSB + i % 5));
         rdc(`IES_OFF_RESULT, ld_exp(i % 5, c));
         rdc(`IES_OFF_AUX, a + imm);
         if (i % 5 > 1)
         begin
            rdc(`IES_OFF_EXCL, a + imm);
            rd(`IES_OFF_STATUS);
            chk({29'h0, q[2], q[6:5]}, {29'h1, (i % 5 == 2) ? 2'h2 : 2'(i % 5 - 3)});
         end
      end
      tally_and_finish();
   end
endmodule // test_instruction_execute_subset
